// File: pkg/pcd_regs.svh
// register indices, field positions, reset values and timing constants of the cable diag block
`ifndef PCD_REGS_SVH
`define PCD_REGS_SVH

`define PCD_IDX_BASIC_CTL 6'h00
`define PCD_IDX_SPECIAL_MODES 6'h12
`define PCD_IDX_TDR_PAT 6'h18
`define PCD_IDX_TDR_CTL 6'h19
`define PCD_IDX_SYM_CNT 6'h1A
`define PCD_IDX_CHIP_RESET_CONTROL_REGISTER 6'h30
`define PCD_IDX_INT_STAT 6'h31
`define PCD_IDX_INT_MASK 6'h32

`define PCD_BASIC_SRST_BIT 15
`define PCD_RESET_PHY_BIT 0

`define PCD_MODE_MSB 7
`define PCD_MODE_LSB 5
`define PCD_MODE_RESET 3'h4
`define PCD_MODE_10HD 3'h0
`define PCD_MODE_10FD 3'h1
`define PCD_MODE_100HD 3'h2
`define PCD_MODE_100FD 3'h3
`define PCD_MODE_AN_100FD 3'h4
`define PCD_MODE_RSVD 3'h5
`define PCD_MODE_PWRDN 3'h6
`define PCD_MODE_AN_ALL 3'h7

`define PCD_PAT_DELAY_BIT 15
`define PCD_PAT_BRK_MSB 14
`define PCD_PAT_BRK_LSB 12
`define PCD_PAT_HI_MSB 11
`define PCD_PAT_HI_LSB 6
`define PCD_PAT_LO_MSB 5
`define PCD_PAT_LO_LSB 0
`define PCD_PAT_RESET 16'h9B9D

`define PCD_CTL_EN_BIT 15
`define PCD_CTL_FILT_BIT 14
`define PCD_CTL_TYPE_MSB 10
`define PCD_CTL_TYPE_LSB 9
`define PCD_CTL_DONE_BIT 8
`define PCD_CTL_DIST_MSB 7
`define PCD_CTL_DIST_LSB 0

`define PCD_SYM_RESET 16'h0000

`define PCD_INT_TDR_DONE_BIT 0
`define PCD_INT_SYM_WRAP_BIT 1

`define PCD_CLK_PERIOD_NS 10
`define PCD_BREAK_BASE_NS 2000000
`define PCD_BREAK_STEP_NS 256000000

`endif

// File: pkg/pcd_pkg.sv
// types shared by the cable diag block
package pcd_pkg;

  typedef enum logic [1:0] {
    PCD_IDLE,
    PCD_BREAK,
    PCD_PULSE
  } pcd_tdr_state_t;

  typedef enum logic [1:0] {
    PCD_CABLE_DEFAULT,
    PCD_CABLE_SHORT,
    PCD_CABLE_OPEN,
    PCD_CABLE_MATCH
  } pcd_cable_t;

endpackage

// File: src/pcd_top.sv
// per-port phy register logic: operating mode, tdr cable diagnostics, symbol error counter
//
// Behaviour
// - mode field bits 7:5 selects speed/duplex/negotiation
// - mode 100: autoneg, advertise 100FD, rx-only CRS
// - 101 reserved, 110 power-down, 111 advertise all
// - delay bit 0 gives 2 ms break
// - break counter adds 256 ms steps
// - high-phase pattern field, reset 101110
// - low-phase pattern field, reset 011101
// - phy reset restores soft-reset-class defaults
// - enable bit self-clears when run completes
// - filter bit steers tdr sample filtering
// - cable type reported in bits 10:9
// - completion flag sticky until reset/restart
// - fault distance reported in bits 7:0
// - count invalid 100TX symbols including idle
// - at most one increment per packet
// - counter wraps to zero past maximum
// - resets to zero, not read-clear, not 10BT
//
// The AHB-Lite interface to the registers is this design's own decision.
`include "pcd_regs.svh"

module pcd_top #(
  parameter int unsigned BREAK_BASE_CYCLES =
    (`PCD_BREAK_BASE_NS + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS,
  parameter int unsigned BREAK_STEP_CYCLES =
    (`PCD_BREAK_STEP_NS + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  output logic tdr_line_break,
  output logic tdr_active,
  output logic tdr_filter_en,
  output logic [5:0] tdr_pattern_high,
  output logic [5:0] tdr_pattern_low,
  input wire logic tdr_done,
  input wire logic [1:0] tdr_cable_type,
  input wire logic [7:0] tdr_fault_distance,
  output logic an_enable,
  output logic adv_100fd_only,
  output logic adv_all,
  output logic power_down,
  output logic speed_100,
  output logic full_duplex,
  output logic crs_rx_only,
  input wire logic rx_symbol_error,
  input wire logic rx_in_packet,
  input wire logic link_is_10
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  logic wr_pend_reg;
  logic [5:0] wr_idx_reg;
  logic [15:0] wdata;
  logic rd_take;
  logic [15:0] rd_word;
  logic wr_basic, wr_modes, wr_pat, wr_ctl, wr_rst, wr_stat, wr_mask;
  logic soft_rst_reg;
  logic phy_rst_reg;
  logic [2:0] mode_reg;
  logic [15:0] tdr_pat_reg;
  logic tdr_en_reg;
  logic tdr_filt_reg;
  logic [1:0] tdr_type_reg;
  logic tdr_done_reg;
  logic [7:0] tdr_dist_reg;
  pcd_pkg::pcd_tdr_state_t tdr_state_reg;
  logic [31:0] brk_cnt_reg;
  logic [31:0] brk_load;
  logic tdr_finish;
  logic [15:0] sym_cnt_reg;
  logic pkt_err_reg;
  logic sym_event;
  logic speed10;
  logic [1:0] int_stat_reg;
  logic [1:0] int_mask_reg;
  logic [1:0] int_event;

  function automatic logic is_idx(input logic [5:0] idx, input logic [5:0] want);
    is_idx = (idx == want);
  endfunction

  // one compare per mode code, shared by the whole mode decode
  function automatic logic mode_is(input logic [2:0] mode, input logic [2:0] code);
    mode_is = (mode == code);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, word writes only (reads of any size), always okay
  // only haddr[7:2] is decoded, so the map repeats every 256 bytes
  // registers are 16 bits wide; the upper half of hrdata reads zero

  assign rd_take = hsel & hready & htrans[1] & ~hwrite;
  assign wdata = hwdata[15:0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 6'h00;
    end else begin
      // the write lands at the data-phase edge, when hwdata stands
      // sub-word writes are dropped rather than merged
      wr_pend_reg <= hsel & hready & htrans[1] & hwrite & (hsize == 3'h2);
      wr_idx_reg <= haddr[7:2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      // read value is captured at the address phase, so reading a register
      // during the data phase of a write to it returns the older value
      if (rd_take) begin
        hrdata <= {16'h0000, rd_word};
      end
    end
  end

  assign wr_basic = wr_pend_reg & is_idx(wr_idx_reg, `PCD_IDX_BASIC_CTL);
  assign wr_modes = wr_pend_reg & is_idx(wr_idx_reg, `PCD_IDX_SPECIAL_MODES);
  assign wr_pat = wr_pend_reg & is_idx(wr_idx_reg, `PCD_IDX_TDR_PAT);
  assign wr_ctl = wr_pend_reg & is_idx(wr_idx_reg, `PCD_IDX_TDR_CTL);
  assign wr_rst = wr_pend_reg & is_idx(wr_idx_reg, `PCD_IDX_CHIP_RESET_CONTROL_REGISTER);
  assign wr_stat = wr_pend_reg & is_idx(wr_idx_reg, `PCD_IDX_INT_STAT);
  assign wr_mask = wr_pend_reg & is_idx(wr_idx_reg, `PCD_IDX_INT_MASK);

  // unmapped indices and write-only bits read as zero
  always_comb begin
    rd_word = 16'h0000;
    if (is_idx(haddr[7:2], `PCD_IDX_BASIC_CTL)) begin
      rd_word[`PCD_BASIC_SRST_BIT] = soft_rst_reg;
    end else if (is_idx(haddr[7:2], `PCD_IDX_SPECIAL_MODES)) begin
      rd_word[`PCD_MODE_MSB:`PCD_MODE_LSB] = mode_reg;
    end else if (is_idx(haddr[7:2], `PCD_IDX_TDR_PAT)) begin
      rd_word = tdr_pat_reg;
    end else if (is_idx(haddr[7:2], `PCD_IDX_TDR_CTL)) begin
      rd_word[`PCD_CTL_EN_BIT] = tdr_en_reg;
      rd_word[`PCD_CTL_FILT_BIT] = tdr_filt_reg;
      rd_word[`PCD_CTL_TYPE_MSB:`PCD_CTL_TYPE_LSB] = tdr_type_reg;
      rd_word[`PCD_CTL_DONE_BIT] = tdr_done_reg;
      rd_word[`PCD_CTL_DIST_MSB:`PCD_CTL_DIST_LSB] = tdr_dist_reg;
    end else if (is_idx(haddr[7:2], `PCD_IDX_SYM_CNT)) begin
      rd_word = sym_cnt_reg;
    end else if (is_idx(haddr[7:2], `PCD_IDX_INT_STAT)) begin
      rd_word[1:0] = int_stat_reg;
    end else if (is_idx(haddr[7:2], `PCD_IDX_INT_MASK)) begin
      rd_word[1:0] = int_mask_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // soft reset bit and phy reset request
  // the symbol tally and interrupt registers are kept across a phy reset

  always_ff @(posedge clk) begin
    if (!rstn) begin
      soft_rst_reg <= 1'b0;
      phy_rst_reg <= 1'b0;
    end else begin
      // the phy reset only acts while the soft reset bit is set
      phy_rst_reg <= wr_rst & wdata[`PCD_RESET_PHY_BIT] & soft_rst_reg;
      if (phy_rst_reg) begin
        soft_rst_reg <= 1'b0;
      end else if (wr_basic) begin
        soft_rst_reg <= wdata[`PCD_BASIC_SRST_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // operating mode

  always_ff @(posedge clk) begin
    if (!rstn || phy_rst_reg) begin
      mode_reg <= `PCD_MODE_RESET;
    end else if (wr_modes && wdata[`PCD_MODE_MSB:`PCD_MODE_LSB] != `PCD_MODE_RSVD) begin
      // the reserved code is refused so the port never runs undefined
      mode_reg <= wdata[`PCD_MODE_MSB:`PCD_MODE_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      an_enable <= 1'b1;
      adv_100fd_only <= 1'b1;
      adv_all <= 1'b0;
      power_down <= 1'b0;
      speed_100 <= 1'b1;
      full_duplex <= 1'b1;
      crs_rx_only <= 1'b1;
    end else begin
      // registered decode, so every mode output leaves the block from a flop
      an_enable <= mode_is(mode_reg, `PCD_MODE_AN_100FD) ||
        mode_is(mode_reg, `PCD_MODE_AN_ALL);
      adv_100fd_only <= mode_is(mode_reg, `PCD_MODE_AN_100FD);
      adv_all <= mode_is(mode_reg, `PCD_MODE_AN_ALL);
      power_down <= mode_is(mode_reg, `PCD_MODE_PWRDN);
      speed_100 <= !mode_is(mode_reg, `PCD_MODE_10HD) &&
        !mode_is(mode_reg, `PCD_MODE_10FD);
      full_duplex <= !mode_is(mode_reg, `PCD_MODE_10HD) &&
        !mode_is(mode_reg, `PCD_MODE_100HD);
      crs_rx_only <= mode_is(mode_reg, `PCD_MODE_100FD) ||
        mode_is(mode_reg, `PCD_MODE_AN_100FD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // tdr pattern and delay control

  always_ff @(posedge clk) begin
    if (!rstn || phy_rst_reg) begin
      tdr_pat_reg <= `PCD_PAT_RESET;
    end else if (wr_pat) begin
      tdr_pat_reg <= wdata;
    end
  end

  assign tdr_pattern_high = tdr_pat_reg[`PCD_PAT_HI_MSB:`PCD_PAT_HI_LSB];
  assign tdr_pattern_low = tdr_pat_reg[`PCD_PAT_LO_MSB:`PCD_PAT_LO_LSB];
  assign tdr_filter_en = tdr_filt_reg;

  // base break always applies; delay bit adds counter times the step
  // 32 bits hold the longest break, the base plus seven steps
  assign brk_load = tdr_pat_reg[`PCD_PAT_DELAY_BIT] ?
    32'(BREAK_BASE_CYCLES) + 32'(tdr_pat_reg[`PCD_PAT_BRK_MSB:`PCD_PAT_BRK_LSB]) *
    32'(BREAK_STEP_CYCLES) : 32'(BREAK_BASE_CYCLES);

  ////////////////////////////////////////////////////////////////////////////////
  // tdr control and result

  // a done pulse outside the pulse phase, or after an abort, is ignored
  assign tdr_finish = tdr_done && (tdr_state_reg == pcd_pkg::PCD_PULSE) && tdr_en_reg;

  always_ff @(posedge clk) begin
    if (!rstn || phy_rst_reg) begin
      tdr_en_reg <= 1'b0;
      tdr_filt_reg <= 1'b0;
      tdr_type_reg <= 2'h0;
      tdr_done_reg <= 1'b0;
      tdr_dist_reg <= 8'h00;
    end else begin
      if (wr_ctl) begin
        tdr_filt_reg <= wdata[`PCD_CTL_FILT_BIT];
        if (wdata[`PCD_CTL_EN_BIT]) begin
          tdr_en_reg <= 1'b1;
          tdr_done_reg <= 1'b0;
          tdr_type_reg <= 2'h0;
          tdr_dist_reg <= 8'h00;
        end else begin
          tdr_en_reg <= 1'b0;
          // completion flag is only cleared by a restart or a reset
          tdr_type_reg <= wdata[`PCD_CTL_TYPE_MSB:`PCD_CTL_TYPE_LSB];
          tdr_dist_reg <= wdata[`PCD_CTL_DIST_MSB:`PCD_CTL_DIST_LSB];
        end
      end
      // completion after the write: the hardware result wins a same-cycle write
      if (tdr_finish) begin
        tdr_en_reg <= 1'b0;
        tdr_done_reg <= 1'b1;
        tdr_type_reg <= tdr_cable_type;
        tdr_dist_reg <= tdr_fault_distance;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || phy_rst_reg) begin
      tdr_state_reg <= pcd_pkg::PCD_IDLE;
      brk_cnt_reg <= 32'h00000000;
      tdr_line_break <= 1'b0;
      tdr_active <= 1'b0;
    end else if (!tdr_en_reg) begin
      // clearing the enable aborts a run at any point
      tdr_state_reg <= pcd_pkg::PCD_IDLE;
      tdr_line_break <= 1'b0;
      tdr_active <= 1'b0;
    end else begin
      unique case (tdr_state_reg)
        pcd_pkg::PCD_IDLE: begin
          tdr_state_reg <= pcd_pkg::PCD_BREAK;
          brk_cnt_reg <= brk_load;
          tdr_line_break <= 1'b1;
        end
        pcd_pkg::PCD_BREAK: begin
          if (brk_cnt_reg <= 32'h00000001) begin
            tdr_state_reg <= pcd_pkg::PCD_PULSE;
            tdr_line_break <= 1'b0;
            tdr_active <= 1'b1;
          end else begin
            brk_cnt_reg <= brk_cnt_reg - 32'h00000001;
          end
        end
        pcd_pkg::PCD_PULSE: begin
          // waits on the far end as long as it takes; an abort is the way out
          if (tdr_done) begin
            tdr_state_reg <= pcd_pkg::PCD_IDLE;
            tdr_active <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // invalid symbol tally
  // read-only and never cleared by a read; the wrap sets a status bit instead

  assign speed10 = link_is_10 || !speed_100;
  // outside a packet every invalid idle symbol counts; inside, only the first
  assign sym_event = rx_symbol_error && !speed10 && (!rx_in_packet || !pkt_err_reg);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pkt_err_reg <= 1'b0;
    end else if (!rx_in_packet) begin
      pkt_err_reg <= 1'b0;
    end else if (rx_symbol_error && !speed10) begin
      pkt_err_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sym_cnt_reg <= `PCD_SYM_RESET;
    end else if (sym_event) begin
      sym_cnt_reg <= sym_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, write one to clear, set beats clear
  // irq trails a status or mask change by one cycle so it leaves from a flop

  always_comb begin
    int_event = 2'h0;
    int_event[`PCD_INT_TDR_DONE_BIT] = tdr_finish;
    int_event[`PCD_INT_SYM_WRAP_BIT] = sym_event && (sym_cnt_reg == 16'hFFFF);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      int_stat_reg <= 2'h0;
      int_mask_reg <= 2'h0;
      irq <= 1'b0;
    end else begin
      int_stat_reg <= (int_stat_reg & ~(wr_stat ? wdata[1:0] : 2'h0)) | int_event;
      if (wr_mask) begin
        int_mask_reg <= wdata[1:0];
      end
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end

endmodule // pcd_top

// File: tb/pcd_props_properties.sv
// concurrent checks on the ports of the cable diag block
module pcd_props #(
  parameter int unsigned BREAK_BASE_CYCLES = 4,
  parameter int unsigned BREAK_STEP_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hresp,
  input wire logic tdr_line_break,
  input wire logic tdr_active,
  input wire logic tdr_done,
  input wire logic an_enable,
  input wire logic adv_100fd_only,
  input wire logic adv_all,
  input wire logic power_down,
  input wire logic full_duplex,
  input wire logic crs_rx_only
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // cycles the line has been held broken so far
  int unsigned brk_cnt;
  always_ff @(posedge clk) begin
    if (!rstn || !tdr_line_break) begin
      brk_cnt <= 0;
    end else begin
      brk_cnt <= brk_cnt + 1;
    end
  end
  sequence pulse_start;
    $rose(tdr_active);
  endsequence
  sequence run_end;
    tdr_active && tdr_done;
  endsequence
  resp_okay_a: assert property (hresp == 1'h0)
    else $error("error response seen");
  break_len_a: assert property (pulse_start |-> brk_cnt >= BREAK_BASE_CYCLES &&
    (brk_cnt - BREAK_BASE_CYCLES) % BREAK_STEP_CYCLES == 0 &&
    brk_cnt <= BREAK_BASE_CYCLES + 7 * BREAK_STEP_CYCLES)
    else $error("line break length off");
  break_first_a: assert property (pulse_start |-> $past(tdr_line_break))
    else $error("pulses started without a line break");
  done_ends_a: assert property (run_end |=> !tdr_active)
    else $error("run kept going after completion");
  no_overlap_a: assert property (!(tdr_line_break && tdr_active))
    else $error("break and pulses overlap");
  mode_fd100_a: assert property (adv_100fd_only |->
    an_enable && full_duplex && crs_rx_only && !adv_all)
    else $error("100 full duplex mode decode wrong");
  mode_all_a: assert property (adv_all |-> an_enable && !power_down)
    else $error("all capable mode decode wrong");
  mode_pwrdn_a: assert property (power_down |-> !adv_100fd_only && !adv_all)
    else $error("power down advertises");
endmodule // pcd_props

bind pcd_top pcd_props #(
  .BREAK_BASE_CYCLES(BREAK_BASE_CYCLES),
  .BREAK_STEP_CYCLES(BREAK_STEP_CYCLES)
) u_props (
  .clk(clk), .rstn(rstn), .hresp(hresp), .tdr_line_break(tdr_line_break),
  .tdr_active(tdr_active), .tdr_done(tdr_done), .an_enable(an_enable),
  .adv_100fd_only(adv_100fd_only), .adv_all(adv_all), .power_down(power_down),
  .full_duplex(full_duplex), .crs_rx_only(crs_rx_only)
);

// File: tb/pcd_cable_model.sv
// behavioural cable and remote end answering a tdr pulse train
module pcd_cable_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tdr_active,
  input wire logic [1:0] res_type,
  input wire logic [7:0] res_dist,
  input wire logic [7:0] res_wait,
  output logic tdr_done,
  output logic [1:0] tdr_cable_type,
  output logic [7:0] tdr_fault_distance
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_cnt;
  logic fired;
  logic hit;
  assign hit = tdr_active && !fired && wait_cnt == res_wait;
  always_ff @(posedge clk) begin
    if (!rstn || !tdr_active) begin
      wait_cnt <= 8'h00;
      fired <= 1'h0;
    end else begin
      wait_cnt <= wait_cnt + 8'h01;
      fired <= fired | hit;
    end
  end
  // one answer per run; results toggle away from the done pulse so stale use shows
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tdr_done <= 1'h0;
      tdr_cable_type <= 2'h0;
      tdr_fault_distance <= 8'h00;
    end else begin
      tdr_done <= hit;
      tdr_cable_type <= hit ? res_type : ~tdr_cable_type;
      tdr_fault_distance <= hit ? res_dist : ~tdr_fault_distance;
    end
  end
endmodule // pcd_cable_model

// File: tb/tb_top.sv
// self-checking bench for the cable diag register block
`include "pcd_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BASE = 4;
  localparam int STEP = 8;
  // per mode: {an, adv100fd, advall, pwrdn, speed100, fd, crs_rx}, unknown bits masked
  localparam logic [6:0] MEXP [8] = '{7'h00, 7'h02, 7'h04, 7'h07, 7'h67, 7'h67, 7'h0C, 7'h50};
  localparam logic [6:0] MMSK [8] = '{7'h7E, 7'h7E, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h3C, 7'h78};
  logic clk, rstn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [2:0] hsize;
  logic [1:0] htrans, tdr_cable_type, res_type;
  logic [7:0] tdr_fault_distance, res_dist, res_wait;
  logic [5:0] tdr_pattern_high, tdr_pattern_low;
  logic tdr_line_break, tdr_active, tdr_filter_en, tdr_done, an_enable, adv_100fd_only;
  logic adv_all, power_down, speed_100, full_duplex, crs_rx_only;
  logic rx_symbol_error, rx_in_packet, link_is_10;
  logic [15:0] rd_val;
  int mismatches, check_count, cycles;

  pcd_top #(.BREAK_BASE_CYCLES(BASE), .BREAK_STEP_CYCLES(STEP)) uut (
    .clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .irq, .tdr_line_break, .tdr_active, .tdr_filter_en,
    .tdr_pattern_high, .tdr_pattern_low, .tdr_done, .tdr_cable_type, .tdr_fault_distance,
    .an_enable, .adv_100fd_only, .adv_all, .power_down, .speed_100, .full_duplex,
    .crs_rx_only, .rx_symbol_error, .rx_in_packet, .link_is_10);
  pcd_cable_model cable (.clk, .rstn, .tdr_active, .res_type, .res_dist, .res_wait,
    .tdr_done, .tdr_cable_type, .tdr_fault_distance);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // the run should take about 66k cycles, most of it the counter wrap
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      give_verdict;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    haddr <= {24'h000000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd_val = hrdata[15:0];
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [15:0] msk, input logic [15:0] exp);
    bus(1'h0, idx, 16'h0000);
    chk(rd_val & msk, exp);
  endtask

  // start a run, time the line break, look at the register mid-run, wait for the end
  task automatic run_tdr(input logic [15:0] ctl, input int len);
    int k;
    bus(1'h1, `PCD_IDX_TDR_CTL, ctl);
    for (k = 0; k < 100 && tdr_line_break !== 1'h1; k++) @(posedge clk);
    k = 0;
    while (tdr_line_break === 1'h1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    chk(16'(k), 16'(len));
    rd_chk(`PCD_IDX_TDR_CTL, 16'hFFFF, ctl & 16'hC000);
    for (k = 0; k < 100 && tdr_active === 1'h1; k++) @(posedge clk);
  endtask

  task automatic pkt(input logic in_pkt, input logic is10, input int c);
    @(posedge clk);
    rx_in_packet <= in_pkt;
    link_is_10 <= is10;
    repeat (c) begin
      @(posedge clk);
      rx_symbol_error <= 1'h1;
      @(posedge clk);
      rx_symbol_error <= 1'h0;
    end
    @(posedge clk);
    rx_in_packet <= 1'h0;
    link_is_10 <= 1'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    rx_symbol_error = 1'h0;
    rx_in_packet = 1'h0;
    link_is_10 = 1'h0;
    res_type = 2'h2;
    res_dist = 8'h5A;
    res_wait = 8'h14;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    rd_chk(`PCD_IDX_TDR_PAT, 16'hFFFF, `PCD_PAT_RESET);
    rd_chk(`PCD_IDX_TDR_CTL, 16'hFFFF, 16'h0000);
    rd_chk(`PCD_IDX_SYM_CNT, 16'hFFFF, `PCD_SYM_RESET);
    chk(16'(tdr_pattern_high), 16'h002E);
    chk(16'(tdr_pattern_low), 16'h001D);
    $display("test reset values done");
    for (int m = 0; m < 8; m++) begin
      bus(1'h1, `PCD_IDX_SPECIAL_MODES, {8'h00, m[2:0], 5'h00});
      repeat (3) @(posedge clk);
      chk(16'({an_enable, adv_100fd_only, adv_all, power_down, speed_100, full_duplex,
        crs_rx_only} & MMSK[m]), 16'(MEXP[m]));
      rd_chk(`PCD_IDX_SPECIAL_MODES, 16'h00E0,
        {8'h00, (m == 5) ? `PCD_MODE_AN_100FD : m[2:0], 5'h00});
    end
    bus(1'h1, `PCD_IDX_SPECIAL_MODES, 16'h0080);
    $display("test modes done");
    bus(1'h1, `PCD_IDX_TDR_PAT, 16'h056A);
    repeat (2) @(posedge clk);
    chk(16'(tdr_pattern_high), 16'h0015);
    chk(16'(tdr_pattern_low), 16'h002A);
    run_tdr(16'hC000, BASE);
    chk(16'(tdr_filter_en), 16'h0001);
    rd_chk(`PCD_IDX_TDR_CTL, 16'hFFFF, 16'h455A);
    rd_chk(`PCD_IDX_INT_STAT, 16'h0001, 16'h0001);
    chk(16'(irq), 16'h0000);
    res_type <= 2'h1;
    res_dist <= 8'h33;
    res_wait <= 8'h28;
    bus(1'h1, `PCD_IDX_TDR_PAT, 16'hA56A);
    run_tdr(16'h8000, BASE + 2 * STEP);
    chk(16'(tdr_filter_en), 16'h0000);
    rd_chk(`PCD_IDX_TDR_CTL, 16'hFFFF, 16'h0333);
    bus(1'h1, `PCD_IDX_INT_MASK, 16'h0001);
    repeat (3) @(posedge clk);
    chk(16'(irq), 16'h0001);
    bus(1'h1, `PCD_IDX_INT_STAT, 16'h0001);
    repeat (3) @(posedge clk);
    chk(16'(irq), 16'h0000);
    bus(1'h1, `PCD_IDX_TDR_CTL, 16'h0000);
    rd_chk(`PCD_IDX_TDR_CTL, 16'h0100, 16'h0100);
    $display("test tdr runs done");
    bus(1'h1, `PCD_IDX_SPECIAL_MODES, 16'h00E0);
    bus(1'h1, `PCD_IDX_BASIC_CTL, 16'h8000);
    bus(1'h1, `PCD_IDX_CHIP_RESET_CONTROL_REGISTER, 16'h0001);
    repeat (2) @(posedge clk);
    rd_chk(`PCD_IDX_TDR_PAT, 16'hFFFF, `PCD_PAT_RESET);
    rd_chk(`PCD_IDX_TDR_CTL, 16'hFFFF, 16'h0000);
    rd_chk(`PCD_IDX_SPECIAL_MODES, 16'h00E0, 16'h0080);
    bus(1'h1, `PCD_IDX_TDR_PAT, 16'h1234);
    bus(1'h1, `PCD_IDX_CHIP_RESET_CONTROL_REGISTER, 16'h0001);
    rd_chk(`PCD_IDX_TDR_PAT, 16'hFFFF, 16'h1234);
    $display("test phy reset done");
    pkt(1'h0, 1'h0, 3);
    rd_chk(`PCD_IDX_SYM_CNT, 16'hFFFF, 16'h0003);
    pkt(1'h1, 1'h0, 4);
    pkt(1'h1, 1'h0, 2);
    rd_chk(`PCD_IDX_SYM_CNT, 16'hFFFF, 16'h0005);
    pkt(1'h0, 1'h1, 3);
    bus(1'h1, `PCD_IDX_SPECIAL_MODES, 16'h0000);
    pkt(1'h0, 1'h0, 2);
    bus(1'h1, `PCD_IDX_SPECIAL_MODES, 16'h0080);
    rd_chk(`PCD_IDX_SYM_CNT, 16'hFFFF, 16'h0005);
    rd_chk(`PCD_IDX_SYM_CNT, 16'hFFFF, 16'h0005);
    @(posedge clk);
    rx_symbol_error <= 1'h1;
    repeat (65531) @(posedge clk);
    rx_symbol_error <= 1'h0;
    rd_chk(`PCD_IDX_SYM_CNT, 16'hFFFF, 16'h0000);
    rd_chk(`PCD_IDX_INT_STAT, 16'h0002, 16'h0002);
    $display("test symbol counter done");
    give_verdict;
  end
endmodule // tb_top
